// file: common/mftr_pkg.sv
// constants, register map and state codes of the timing relay
`default_nettype none
package mftr_pkg;
  // ----------------------------------------
  // bus and widths
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int IVL_W = 24;
  localparam int FN_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SECOND = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;
  // status word bit positions
  localparam int STAT_RELAY_BIT = 0;
  localparam int STAT_SUPPLY_BIT = 1;
  localparam int STAT_CONTACT_BIT = 2;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_STATE_LSB = 4;
  // ----------------------------------------
  // function codes and reset values
  // ----------------------------------------
  localparam logic [FN_W-1:0] FN_ASYM_PAUSE = 5'h01;
  localparam logic [FN_W-1:0] FN_ASYM_PULSE = 5'h02;
  localparam logic [FN_W-1:0] FN_ON_OFF_DELAY = 5'h03;
  localparam logic [FN_W-1:0] FN_DELAY_SHOT_PWR = 5'h04;
  localparam logic [FN_W-1:0] FN_DELAY_SHOT_CON = 5'h05;
  localparam logic [FN_W-1:0] FN_SHOT_BOTH = 5'h06;
  localparam logic [FN_W-1:0] FN_PULSE_MON = 5'h07;
  localparam logic [FN_W-1:0] FN_ON_DELAY_PWR = 5'h08;
  localparam logic [FN_W-1:0] FN_SHOT_PWR = 5'h09;
  localparam logic [FN_W-1:0] FN_OFF_DELAY = 5'h0A;
  localparam logic [FN_W-1:0] FN_SHOT_LEAD = 5'h0B;
  localparam logic [FN_W-1:0] FN_SHOT_TRAIL = 5'h0C;
  localparam logic [FN_W-1:0] FN_DELAY_TRAIL_OFF = 5'h0D;
  localparam logic [FN_W-1:0] FN_FLASH_PAUSE = 5'h0E;
  localparam logic [FN_W-1:0] FN_FLASH_ON = 5'h10;
  localparam logic [FN_W-1:0] FN_DELAY_LEAD_OFF = 5'h11;
  localparam logic [FN_W-1:0] FN_RESET = 5'h01;
  localparam logic [IVL_W-1:0] FIRST_RESET = 24'h0003E8;
  localparam logic [IVL_W-1:0] SECOND_RESET = 24'h0003E8;
  // ----------------------------------------
  // timing: one interval tick per millisecond
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RUN1 = 3'h1,
    ST_RUN2 = 3'h2,
    ST_HOLD = 3'h3,
    ST_DONE = 3'h4
  } mftr_state_e;
endpackage : mftr_pkg
`default_nettype wire

// file: common/mftr_tmr_if.sv
// link between the sequencer and its interval timer
`default_nettype none
interface mftr_tmr_if #(parameter int W = 24) ();
  logic start;
  logic stop;
  logic [W-1:0] limit;
  logic expired;
  logic running;
  modport ctl (output start, output stop, output limit, input expired, input running);
  modport tmr (input start, input stop, input limit, output expired, output running);
endinterface : mftr_tmr_if
`default_nettype wire

// file: hw/mftr_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none
module mftr_sync #(parameter int N = 2) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] d_i,
  output logic [N-1:0] q_o
);
  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] q;
  } mftr_sync_s;
  mftr_sync_s r_reg;
  mftr_sync_s r_next;

  // first stage feeds only the second
  always_comb begin
    r_next = r_reg;
    r_next.meta = d_i;
    r_next.q = r_reg.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.q;
endmodule : mftr_sync
`default_nettype wire

// file: hw/mftr_timer.sv
// interval timer: tick prescaler plus tick counter
`default_nettype none
module mftr_timer #(
  parameter int W = 24,
  parameter int TICK_CYCLES = 20000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  mftr_tmr_if.tmr t
);
  localparam int DW = $clog2(TICK_CYCLES + 1);
  typedef struct packed {
    logic [DW-1:0] div;
    logic [W-1:0] cnt;
    logic [W-1:0] lim;
    logic run;
    logic exp;
  } mftr_timer_s;
  mftr_timer_s r_reg;
  mftr_timer_s r_next;

  // start wins over stop; limit of zero acts as one tick
  always_comb begin
    r_next = r_reg;
    r_next.exp = 1'b0;
    if (t.start) begin
      r_next.run = 1'b1;
      r_next.div = '0;
      r_next.cnt = '0;
      r_next.lim = t.limit;
    end else if (t.stop) begin
      r_next.run = 1'b0;
    end else if (r_reg.run) begin
      if (r_reg.div == DW'(TICK_CYCLES - 1)) begin
        r_next.div = '0;
        if (r_reg.lim == '0 || r_reg.cnt == r_reg.lim - W'(1)) begin
          r_next.run = 1'b0;
          r_next.exp = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + W'(1);
        end
      end else begin
        r_next.div = r_reg.div + DW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign t.expired = r_reg.exp;
  assign t.running = r_reg.run;
endmodule : mftr_timer
`default_nettype wire

// file: hw/mftr_relay.sv
// multi-function timing relay sequencer with avalon register slave
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`default_nettype none
module mftr_relay #(
  parameter int TICK_CYCLES = mftr_pkg::TICK_CYCLES
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic SUPPLY_I,
  input wire logic CONTACT_I,
  input wire logic [mftr_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [mftr_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [mftr_pkg::DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic RELAY_O
);
  import mftr_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mftr_state_e st;
    logic aux;
    logic relay;
    logic con_prev;
    logic [FN_W-1:0] fn;
    logic [IVL_W-1:0] first;
    logic [IVL_W-1:0] second;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
  } mftr_core_s;
  mftr_core_s r_reg;
  mftr_core_s r_next;

  logic [1:0] pins_s;
  logic supply_s;
  logic con_s;
  logic rise;
  logic fall;
  logic live;
  logic cfg_wr;
  logic sel2;
  logic asym;
  logic on_first;
  logic [DATA_W-1:0] rd_word;

  mftr_tmr_if #(.W(IVL_W)) tmr_if ();

  // byte-lane merge for register writes
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_w,
                                                 input logic [DATA_W-1:0] new_w,
                                                 input logic [3:0] be);
    logic [DATA_W-1:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return m;
  endfunction : be_merge

  // ----------------------------------------
  // pin synchronisers and interval timer
  // ----------------------------------------
  mftr_sync #(.N(2)) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i({SUPPLY_I, CONTACT_I}),
    .q_o(pins_s)
  );

  mftr_timer #(.W(IVL_W), .TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .t(tmr_if.tmr)
  );

  // contact edges and bus strobes
  assign supply_s = pins_s[1];
  assign con_s = pins_s[0];
  assign rise = con_s && !r_reg.con_prev;
  assign fall = !con_s && r_reg.con_prev;
  assign cfg_wr = AVS_WRITE_I && !r_reg.waitreq && (AVS_ADDRESS_I == ADDR_CTRL);
  assign live = supply_s && !cfg_wr;
  assign asym = (r_reg.fn == FN_ASYM_PAUSE) || (r_reg.fn == FN_ASYM_PULSE);
  assign on_first = (r_reg.fn == FN_ASYM_PULSE) || (r_reg.fn == FN_FLASH_ON);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_word = '0;
    unique case (AVS_ADDRESS_I)
      ADDR_CTRL: rd_word[FN_W-1:0] = r_reg.fn;
      ADDR_FIRST: rd_word[IVL_W-1:0] = r_reg.first;
      ADDR_SECOND: rd_word[IVL_W-1:0] = r_reg.second;
      ADDR_STATUS: begin
        rd_word[STAT_RELAY_BIT] = r_reg.relay;
        rd_word[STAT_SUPPLY_BIT] = supply_s;
        rd_word[STAT_CONTACT_BIT] = con_s;
        rd_word[STAT_RUN_BIT] = tmr_if.running;
        rd_word[STAT_STATE_LSB +: 3] = r_reg.st;
      end
      default: rd_word = '0;
    endcase
  end

  // ----------------------------------------
  // sequencer and register file
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    tmr_if.start = 1'b0;
    tmr_if.stop = 1'b0;
    sel2 = 1'b0;
    r_next.con_prev = con_s;
    // one wait cycle, then answer for one cycle
    r_next.waitreq = 1'b1;
    if ((AVS_READ_I || AVS_WRITE_I) && r_reg.waitreq) begin
      r_next.waitreq = 1'b0;
      r_next.rdata = rd_word;
    end
    unique case (r_reg.fn)
      FN_ASYM_PAUSE, FN_ASYM_PULSE, FN_FLASH_PAUSE, FN_FLASH_ON: begin
        // flashers; symmetric ones reuse the first interval
        if (r_reg.st == ST_IDLE) begin
          r_next.relay = on_first;
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (tmr_if.expired) begin
          r_next.relay = !r_reg.relay;
          tmr_if.start = 1'b1;
          sel2 = asym && (r_reg.st == ST_RUN1);
          r_next.st = (r_reg.st == ST_RUN1) ? ST_RUN2 : ST_RUN1;
        end
      end
      FN_ON_OFF_DELAY: begin
        if (r_reg.st == ST_IDLE && con_s) begin
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1) begin
          if (tmr_if.expired) begin
            r_next.relay = 1'b1;
            r_next.st = ST_HOLD;
          end else if (!con_s) begin
            tmr_if.stop = 1'b1;
            r_next.st = ST_IDLE;
          end
        end else if (r_reg.st == ST_HOLD && !con_s) begin
          tmr_if.start = 1'b1;
          sel2 = 1'b1;
          r_next.st = ST_RUN2;
        end else if (r_reg.st == ST_RUN2) begin
          if (con_s) begin
            tmr_if.stop = 1'b1; // reclosure keeps it on
            r_next.st = ST_HOLD;
          end else if (tmr_if.expired) begin
            r_next.relay = 1'b0;
            r_next.st = ST_IDLE;
          end
        end
      end
      FN_DELAY_SHOT_PWR, FN_DELAY_SHOT_CON: begin
        // power start runs once; contact start rearms
        if (r_reg.st == ST_IDLE && (r_reg.fn == FN_DELAY_SHOT_PWR || rise)) begin
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1 && tmr_if.expired) begin
          r_next.relay = 1'b1;
          tmr_if.start = 1'b1;
          sel2 = 1'b1;
          r_next.st = ST_RUN2;
        end else if (r_reg.st == ST_RUN2 && tmr_if.expired) begin
          r_next.relay = 1'b0;
          r_next.st = (r_reg.fn == FN_DELAY_SHOT_PWR) ? ST_DONE : ST_IDLE;
        end
      end
      FN_SHOT_BOTH: begin
        if (r_reg.st == ST_IDLE && (rise || fall)) begin
          r_next.relay = 1'b1;
          tmr_if.start = 1'b1;
          sel2 = fall;
          r_next.st = fall ? ST_RUN2 : ST_RUN1;
        end else if (r_reg.st != ST_IDLE && tmr_if.expired) begin
          r_next.relay = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      FN_PULSE_MON: begin
        if (r_reg.st == ST_IDLE) begin
          r_next.relay = 1'b1;
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1 && tmr_if.expired) begin
          tmr_if.start = 1'b1;
          sel2 = 1'b1;
          r_next.aux = 1'b0;
          r_next.st = ST_RUN2;
        end else if (r_reg.st == ST_RUN2) begin
          if (tmr_if.expired) begin
            r_next.relay = 1'b0;
            r_next.st = ST_DONE;
          end else if (fall && r_reg.aux) begin
            tmr_if.start = 1'b1;
            sel2 = 1'b1;
            r_next.aux = 1'b0;
          end else if (rise) begin
            r_next.aux = 1'b1;
          end
        end
      end
      FN_ON_DELAY_PWR: begin
        if (r_reg.st == ST_IDLE) begin
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1 && tmr_if.expired) begin
          r_next.relay = 1'b1;
          r_next.st = ST_HOLD;
        end
      end
      FN_SHOT_PWR, FN_SHOT_LEAD, FN_SHOT_TRAIL: begin
        // one pulse; trigger differs, contact ignored while it runs
        if (r_reg.st == ST_IDLE && ((r_reg.fn == FN_SHOT_PWR) ||
            (r_reg.fn == FN_SHOT_LEAD && rise) || (r_reg.fn == FN_SHOT_TRAIL && fall))) begin
          r_next.relay = 1'b1;
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1 && tmr_if.expired) begin
          r_next.relay = 1'b0;
          r_next.st = (r_reg.fn == FN_SHOT_PWR) ? ST_DONE : ST_IDLE;
        end
      end
      FN_OFF_DELAY: begin
        if (con_s) begin
          r_next.relay = 1'b1;
          tmr_if.stop = 1'b1;
          r_next.st = ST_HOLD;
        end else if (r_reg.st == ST_HOLD) begin
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1 && tmr_if.expired) begin
          r_next.relay = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      FN_DELAY_TRAIL_OFF: begin
        if (r_reg.st == ST_IDLE && con_s) begin
          tmr_if.start = 1'b1;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1) begin
          if (tmr_if.expired) begin
            r_next.relay = 1'b1;
            r_next.st = ST_HOLD;
          end else if (!con_s) begin
            tmr_if.stop = 1'b1;
            r_next.st = ST_IDLE;
          end
        end else if (r_reg.st == ST_HOLD && !con_s) begin
          r_next.relay = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      FN_DELAY_LEAD_OFF: begin
        // aux remembers an opening since the last closure
        if (r_reg.st == ST_IDLE && rise) begin
          tmr_if.start = 1'b1;
          r_next.aux = 1'b0;
          r_next.st = ST_RUN1;
        end else if (r_reg.st == ST_RUN1 && tmr_if.expired) begin
          r_next.relay = 1'b1;
          r_next.aux = !con_s;
          r_next.st = ST_HOLD;
        end else if (r_reg.st != ST_IDLE && rise && r_reg.aux) begin
          tmr_if.stop = 1'b1;
          r_next.relay = 1'b0;
          r_next.st = ST_IDLE;
        end else if (fall) begin
          r_next.aux = 1'b1;
        end
      end
      default: begin
        r_next.relay = 1'b0;
        r_next.st = ST_IDLE;
        tmr_if.stop = 1'b1;
      end
    endcase
    // register writes; a new function restarts from idle
    if (AVS_WRITE_I && !r_reg.waitreq) begin
      unique case (AVS_ADDRESS_I)
        ADDR_CTRL: r_next.fn = FN_W'(be_merge(DATA_W'(r_reg.fn), AVS_WRITEDATA_I,
                                             AVS_BYTEENABLE_I));
        ADDR_FIRST: r_next.first = IVL_W'(be_merge(DATA_W'(r_reg.first), AVS_WRITEDATA_I,
                                                   AVS_BYTEENABLE_I));
        ADDR_SECOND: r_next.second = IVL_W'(be_merge(DATA_W'(r_reg.second), AVS_WRITEDATA_I,
                                                     AVS_BYTEENABLE_I));
        default: r_next.fn = r_reg.fn;
      endcase
    end
    // supply loss or function change clears all timing
    if (!supply_s || cfg_wr) begin
      r_next.st = ST_IDLE;
      r_next.relay = 1'b0;
      r_next.aux = 1'b0;
      tmr_if.start = 1'b0;
      tmr_if.stop = 1'b1;
    end
    tmr_if.limit = sel2 ? r_reg.second : r_reg.first;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_reg <= '{st: ST_IDLE, aux: 1'b0, relay: 1'b0, con_prev: 1'b0, fn: FN_RESET,
                 first: FIRST_RESET, second: SECOND_RESET, waitreq: 1'b1, rdata: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign RELAY_O = r_reg.relay;
  assign AVS_WAITREQUEST_O = r_reg.waitreq;
  assign AVS_READDATA_O = r_reg.rdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking dcb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  supply_loss_a: assert property (
    !supply_s |=> !RELAY_O && r_reg.st == ST_IDLE && !tmr_if.running)
    else $error("output or timer alive after supply loss");
  timer_start_a: assert property (
    tmr_if.start |=> tmr_if.running && !tmr_if.expired)
    else $error("timer did not start");
  asym_pause_a: assert property (
    live && r_reg.fn == FN_ASYM_PAUSE && r_reg.st == ST_IDLE
    |=> !RELAY_O && r_reg.st == ST_RUN1 ##1 !RELAY_O)
    else $error("pause-first flasher began on");
  asym_pulse_a: assert property (
    live && r_reg.fn == FN_ASYM_PULSE && r_reg.st == ST_RUN1 && tmr_if.expired
    |=> $fell(RELAY_O) && r_reg.st == ST_RUN2)
    else $error("pulse-first flasher did not switch off");
  early_open_a: assert property (
    live && r_reg.fn == FN_ON_OFF_DELAY && r_reg.st == ST_RUN1 && !con_s && !tmr_if.expired
    |=> !RELAY_O && r_reg.st == ST_IDLE && !tmr_if.running)
    else $error("early opening did not clear timing");
  pwr_shot_done_a: assert property (
    live && r_reg.fn == FN_DELAY_SHOT_PWR && r_reg.st == ST_DONE |=> !RELAY_O)
    else $error("delayed shot turned on again");
  con_shot_wait_a: assert property (
    live && r_reg.fn == FN_DELAY_SHOT_CON && r_reg.st == ST_RUN1 && !tmr_if.expired
    |=> !RELAY_O && r_reg.st == ST_RUN1)
    else $error("contact disturbed the delay");
  both_edges_a: assert property (
    live && r_reg.fn == FN_SHOT_BOTH && r_reg.st == ST_IDLE && fall
    |=> RELAY_O && r_reg.st == ST_RUN2)
    else $error("opening pulse missing");
  mon_latch_a: assert property (
    live && r_reg.fn == FN_PULSE_MON && r_reg.st == ST_DONE |=> !RELAY_O && r_reg.st == ST_DONE)
    else $error("monitor latch released");
  off_delay_a: assert property (
    live && r_reg.fn == FN_OFF_DELAY && con_s |=> RELAY_O && r_reg.st == ST_HOLD)
    else $error("closure did not turn output on");
  reclose_a: assert property (
    live && r_reg.fn == FN_OFF_DELAY && r_reg.st == ST_RUN1 && con_s |=> !tmr_if.running)
    else $error("reclosure did not cancel timing");
  pwr_delay_a: assert property (
    live && r_reg.fn == FN_ON_DELAY_PWR && r_reg.st == ST_HOLD |=> RELAY_O)
    else $error("power delay output dropped");
  lead_shot_a: assert property (
    live && r_reg.fn == FN_SHOT_LEAD && r_reg.st == ST_RUN1 && !tmr_if.expired
    |=> RELAY_O && r_reg.st == ST_RUN1)
    else $error("leading shot cut short");
  pwr_shot_a: assert property (
    live && r_reg.fn == FN_SHOT_PWR && r_reg.st == ST_IDLE |=> RELAY_O && tmr_if.running)
    else $error("power shot did not start");
  trail_shot_a: assert property (
    live && r_reg.fn == FN_SHOT_TRAIL && r_reg.st == ST_IDLE && fall |=> RELAY_O)
    else $error("trailing shot missed the opening");
  trail_off_a: assert property (
    live && r_reg.fn == FN_DELAY_TRAIL_OFF && r_reg.st == ST_HOLD && !con_s
    |=> !RELAY_O && r_reg.st == ST_IDLE)
    else $error("output held after opening");
  flash_on_a: assert property (
    live && r_reg.fn == FN_FLASH_ON && r_reg.st == ST_IDLE |=> RELAY_O)
    else $error("on-first flasher began off");
  flash_pause_a: assert property (
    live && r_reg.fn == FN_FLASH_PAUSE && r_reg.st == ST_RUN2 && tmr_if.expired
    |=> $fell(RELAY_O))
    else $error("pause-first flasher did not toggle");
  lead_off_a: assert property (
    live && r_reg.fn == FN_DELAY_LEAD_OFF && r_reg.st == ST_HOLD && rise && r_reg.aux
    |=> !RELAY_O && r_reg.st == ST_IDLE)
    else $error("reopen and close did not release output");
endmodule : mftr_relay
`default_nettype wire

// file: verification/mftr_field_model.sv
// model of the control contact and the supply sense at the relay pins
`default_nettype none
module mftr_field_model (
  input wire logic clk_i,
  input wire logic supply_cmd_i,
  input wire logic contact_cmd_i,
  output logic supply_o = 1'b0,
  output logic contact_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // switch levels move only just after an edge and stay as plain levels
  always @(posedge clk_i) begin
    supply_o <= supply_cmd_i;
    contact_o <= contact_cmd_i;
  end
endmodule : mftr_field_model
`default_nettype wire

// file: verification/test_multi_function_timing_relay.sv
// self-checking bench of the timing relay
`default_nettype none
module test_multi_function_timing_relay;
  timeunit 1ns;
  timeprecision 1ns;
  import mftr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_cmd = 1'b0;
  logic con_cmd = 1'b0;
  logic sup, con, rd, wr, wait_o, relay;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0, rdata, q;
  int failures = 0;
  int num_checks = 0;
  // power-started functions and the relay level at four sample points
  logic [8:0] rows [8] = '{{5'h01, 4'h5}, {5'h02, 4'hA}, {5'h04, 4'h4}, {5'h07, 4'hC},
    {5'h08, 4'h7}, {5'h09, 4'h8}, {5'h0E, 4'h5}, {5'h10, 4'hA}};
  initial rd = 1'b0;
  initial wr = 1'b0;
  always #25 clk = ~clk;
  mftr_field_model field (.clk_i(clk), .supply_cmd_i(sup_cmd), .contact_cmd_i(con_cmd),
    .supply_o(sup), .contact_o(con));
  mftr_relay #(.TICK_CYCLES(4)) uut (.REF_CLK_I(clk), .RST_I(rst), .SUPPLY_I(sup),
    .CONTACT_I(con), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .RELAY_O(relay));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    // one idle edge so back-to-back calls never re-raise a strobe in one step
    @(posedge clk);
    if (n >= 50) begin
      failures++;
      report_and_stop();
    end
  endtask : bus
  // set pin levels, let n cycles pass, then check the relay level
  task step(input logic s, input logic c, input int n, input logic e);
    sup_cmd <= s;
    con_cmd <= c;
    repeat (n) @(posedge clk);
    cmp({31'h0, relay}, {31'h0, e});
  endtask : step
  task setfn(input logic [4:0] f);
    step(1'b0, 1'b0, 5, 1'b0);
    bus(1'b1, ADDR_CTRL, {27'h0, f});
  endtask : setfn
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    cmp({30'h0, wait_o, relay}, 32'h2);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, ADDR_CTRL, 32'h0);
    cmp(q, {27'h0, FN_RESET});
    bus(1'b0, ADDR_FIRST, 32'h0);
    cmp(q, {8'h0, FIRST_RESET});
    bus(1'b0, 4'h2, 32'h0);
    cmp(q, 32'h0);
    bus(1'b1, ADDR_FIRST, 32'h3);
    bus(1'b1, ADDR_SECOND, 32'h5);
    bus(1'b0, ADDR_SECOND, 32'h0);
    cmp(q, 32'h5);
    // 12 and 20 cycle intervals, sampled at 6, 20, 42 and 54 cycles
    foreach (rows[i]) begin
      setfn(rows[i][8:4]);
      step(1'b1, 1'b0, 6, rows[i][3]);
      step(1'b1, 1'b0, 14, rows[i][2]);
      step(1'b1, 1'b0, 22, rows[i][1]);
      step(1'b1, 1'b0, 12, rows[i][0]);
    end
    setfn(FN_ON_DELAY_PWR);
    step(1'b1, 1'b0, 20, 1'b1);
    // status: relay on, supply seen, contact open, timer idle, hold state
    bus(1'b0, ADDR_STATUS, 32'h0);
    cmp(q, {25'h0, ST_HOLD, 4'h3});
    step(1'b0, 1'b0, 5, 1'b0);
    setfn(FN_SHOT_LEAD);
    step(1'b1, 1'b0, 10, 1'b0);
    step(1'b1, 1'b1, 6, 1'b1);
    step(1'b1, 1'b0, 3, 1'b1);
    step(1'b1, 1'b1, 3, 1'b1);
    step(1'b1, 1'b1, 12, 1'b0);
    setfn(FN_OFF_DELAY);
    step(1'b1, 1'b1, 6, 1'b1);
    step(1'b1, 1'b0, 8, 1'b1);
    step(1'b1, 1'b1, 20, 1'b1);
    step(1'b1, 1'b0, 8, 1'b1);
    step(1'b1, 1'b0, 10, 1'b0);
    setfn(FN_ON_OFF_DELAY);
    step(1'b1, 1'b1, 6, 1'b0);
    step(1'b1, 1'b0, 20, 1'b0);
    step(1'b1, 1'b1, 20, 1'b1);
    step(1'b1, 1'b0, 12, 1'b1);
    step(1'b1, 1'b0, 14, 1'b0);
    // contact-started pulses: trailing shot, two-edge shots, delayed shot
    setfn(FN_SHOT_TRAIL);
    step(1'b1, 1'b1, 8, 1'b0);
    step(1'b1, 1'b0, 6, 1'b1);
    step(1'b1, 1'b1, 4, 1'b1);
    step(1'b1, 1'b0, 4, 1'b1);
    step(1'b1, 1'b0, 6, 1'b0);
    setfn(FN_SHOT_BOTH);
    step(1'b1, 1'b1, 6, 1'b1);
    step(1'b1, 1'b1, 14, 1'b0);
    step(1'b1, 1'b0, 6, 1'b1);
    step(1'b1, 1'b1, 14, 1'b1);
    step(1'b1, 1'b1, 8, 1'b0);
    setfn(FN_DELAY_SHOT_CON);
    step(1'b1, 1'b1, 6, 1'b0);
    step(1'b1, 1'b0, 14, 1'b1);
    step(1'b1, 1'b1, 10, 1'b1);
    step(1'b1, 1'b1, 12, 1'b0);
    // delayed-on functions released by the contact
    setfn(FN_DELAY_TRAIL_OFF);
    step(1'b1, 1'b1, 10, 1'b0);
    step(1'b1, 1'b0, 14, 1'b0);
    step(1'b1, 1'b1, 20, 1'b1);
    step(1'b1, 1'b0, 6, 1'b0);
    setfn(FN_DELAY_LEAD_OFF);
    step(1'b1, 1'b1, 5, 1'b0);
    step(1'b1, 1'b0, 3, 1'b0);
    step(1'b1, 1'b1, 8, 1'b0);
    step(1'b1, 1'b1, 10, 1'b0);
    step(1'b1, 1'b0, 4, 1'b0);
    step(1'b1, 1'b1, 20, 1'b1);
    step(1'b1, 1'b0, 6, 1'b1);
    step(1'b1, 1'b1, 6, 1'b0);
    // monitor window kept open by one contact pulse, then latched off
    setfn(FN_PULSE_MON);
    step(1'b1, 1'b0, 20, 1'b1);
    step(1'b1, 1'b1, 6, 1'b1);
    step(1'b1, 1'b0, 14, 1'b1);
    step(1'b1, 1'b0, 14, 1'b0);
    step(1'b1, 1'b1, 10, 1'b0);
    // supply loss in mid-sequence clears elapsed time or drops the pulse
    setfn(FN_DELAY_SHOT_PWR);
    step(1'b1, 1'b0, 10, 1'b0);
    step(1'b0, 1'b0, 5, 1'b0);
    step(1'b1, 1'b0, 14, 1'b0);
    step(1'b1, 1'b0, 6, 1'b1);
    setfn(FN_SHOT_PWR);
    step(1'b1, 1'b0, 8, 1'b1);
    step(1'b0, 1'b0, 5, 1'b0);
    // unused function code keeps the output off
    setfn(5'h0F);
    step(1'b1, 1'b1, 10, 1'b0);
    // reset in mid-run drops the output and restores the registers
    setfn(FN_ASYM_PULSE);
    step(1'b1, 1'b0, 6, 1'b1);
    rst <= 1'b1;
    @(posedge clk);
    cmp({30'h0, wait_o, relay}, 32'h2);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, ADDR_FIRST, 32'h0);
    cmp(q, {8'h0, FIRST_RESET});
    step(1'b1, 1'b0, 20, 1'b0);
    report_and_stop();
  end
endmodule : test_multi_function_timing_relay
`default_nettype wire
